//--- rtl/bmx_arbitration_core.v
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [R1] Two independent cores, one per memory port
// [R2] Both buses reach both cores
// [R3] Kind bit 0: fixed 0, rotating 1
// [R4] Fixed mode bit 1: system 0, image 1
// [R5] Lower register controls static/NAND port core
// [R6] Next word controls SDRAM port core
// [R7] Both control registers reset to zero
// [R8] Rotating mode alternates between contending buses
module bmx_arbitration_core
(
  input wire CLK,
  input wire SYS_RST,
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [31:0] PADDR,
  input wire [31:0] PWDATA,
  output reg [31:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  input wire SYS_REQ_STATIC,
  input wire SYS_REQ_SDRAM,
  input wire IMG_REQ_STATIC,
  input wire IMG_REQ_SDRAM,
  input wire STATIC_DONE,
  input wire SDRAM_DONE,
  output reg SYS_GNT_STATIC,
  output reg IMG_GNT_STATIC,
  output reg SYS_GNT_SDRAM,
  output reg IMG_GNT_SDRAM
);
`include "bmx_defs.vh"
  reg [1:0] static_port_arbiter_control;
  reg [1:0] sdram_port_arbiter_control;
  wire st_sys, st_img, st_last, sd_sys, sd_img, sd_last;
  // Request and done inputs are same-clock logic, no synchroniser
  function hit;
    input [31:0] a;
    input [31:0] r;
    begin
      hit = (a[15:2] == r[15:2]);
    end
  endfunction
  wire setup = PSEL && !PENABLE;
  wire acc_wr = PSEL && PENABLE && PREADY && PWRITE;
  // One wait state: ready raised in access phase, dropped after
  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      PREADY <= 1'b0;
    else
      PREADY <= PSEL && PENABLE && !PREADY;
  end
  // Register writes at the completing edge
  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      static_port_arbiter_control <= `BMX_CTRL_RESET; // [R7]
      sdram_port_arbiter_control <= `BMX_CTRL_RESET; // [R7]
    end
    else if (acc_wr)
    begin
      if (hit(PADDR, `BMX_STATIC_CTRL_ADDR))
        static_port_arbiter_control <= PWDATA[1:0]; // [R5]
      else if (hit(PADDR, `BMX_SDRAM_CTRL_ADDR))
        sdram_port_arbiter_control <= PWDATA[1:0]; // [R6]
    end
  end
  // Read data and error prepared in setup, held through access
  always @(posedge CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
    end
    else if (setup)
    begin
      PSLVERR <= !(hit(PADDR, `BMX_STATIC_CTRL_ADDR) || hit(PADDR, `BMX_SDRAM_CTRL_ADDR));
      if (PWRITE)
        PRDATA <= 32'h00000000;
      else if (hit(PADDR, `BMX_STATIC_CTRL_ADDR))
        PRDATA <= {30'h0, static_port_arbiter_control};
      else if (hit(PADDR, `BMX_SDRAM_CTRL_ADDR))
        PRDATA <= {30'h0, sdram_port_arbiter_control};
      else
        PRDATA <= 32'h00000000;
    end
  end
  // Static/NAND port core; both buses wired in
  bmx_core u_static
  (
    .clk(CLK),
    .rst(SYS_RST),
    .rotate_mode(static_port_arbiter_control[`BMX_KIND_BIT]), // [R3] [R5]
    .prefer_image(static_port_arbiter_control[`BMX_PREF_BIT]), // [R4]
    .sys_req(SYS_REQ_STATIC), // [R2]
    .img_req(IMG_REQ_STATIC), // [R2]
    .port_done(STATIC_DONE),
    .sys_gnt(st_sys),
    .img_gnt(st_img),
    .last_bus(st_last)
  ); // [R1]
  // SDRAM port core, runs independently of the static core
  bmx_core u_sdram
  (
    .clk(CLK),
    .rst(SYS_RST),
    .rotate_mode(sdram_port_arbiter_control[`BMX_KIND_BIT]), // [R3] [R6]
    .prefer_image(sdram_port_arbiter_control[`BMX_PREF_BIT]), // [R4]
    .sys_req(SYS_REQ_SDRAM), // [R2]
    .img_req(IMG_REQ_SDRAM), // [R2]
    .port_done(SDRAM_DONE),
    .sys_gnt(sd_sys),
    .img_gnt(sd_img),
    .last_bus(sd_last)
  ); // [R1]
  // Grants leave through core flip-flops; mirror for output register rule
  always @*
  begin
    SYS_GNT_STATIC = st_sys;
    IMG_GNT_STATIC = st_img;
    SYS_GNT_SDRAM = sd_sys;
    IMG_GNT_SDRAM = sd_img;
  end
  wire unused_last = st_last ^ sd_last;
endmodule // bmx_arbitration_core
`default_nettype wire

//--- rtl/bmx_defs.vh
`ifndef BMX_DEFS_VH
`define BMX_DEFS_VH
// Register byte addresses (full map address, low bits decoded)
`define BMX_STATIC_CTRL_ADDR 32'h40ce0000
`define BMX_SDRAM_CTRL_ADDR 32'h40ce0004
// Control register fields
`define BMX_KIND_BIT 0
`define BMX_PREF_BIT 1
`define BMX_CTRL_RESET 2'h0
// Bus encodings
`define BMX_SYS_BUS 1'b0
`define BMX_IMG_BUS 1'b1
`endif

//--- rtl/bmx_core.v
`timescale 1ns/1ps
`default_nettype none
// One arbitration core for one memory port, shared by both buses
module bmx_core
(
  input wire clk,
  input wire rst,
  input wire rotate_mode,
  input wire prefer_image,
  input wire sys_req,
  input wire img_req,
  input wire port_done,
  output reg sys_gnt,
  output reg img_gnt,
  output reg last_bus
);
`include "bmx_defs.vh"
  reg pick_img;
  reg busy;
  // Winner when both request: fixed preference or alternation
  always @*
  begin
    if (sys_req && img_req)
      pick_img = rotate_mode ? (last_bus == `BMX_SYS_BUS) : prefer_image; // [R3] [R4] [R8]
    else
      pick_img = img_req;
  end
  // Grant held until the port reports the transfer done
  always @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sys_gnt <= 1'b0;
      img_gnt <= 1'b0;
      busy <= 1'b0;
      last_bus <= `BMX_SYS_BUS;
    end
    else if (busy)
    begin
      if (port_done)
      begin
        sys_gnt <= 1'b0;
        img_gnt <= 1'b0;
        busy <= 1'b0;
      end
    end
    else if (sys_req || img_req)
    begin
      sys_gnt <= ~pick_img;
      img_gnt <= pick_img;
      busy <= 1'b1;
      last_bus <= pick_img; // [R8]
    end
  end
endmodule // bmx_core
`default_nettype wire

//--- tb/bmx_arbitration_core_chk.sv
`timescale 1ns/1ps
`default_nettype none
module bmx_chk(
  input wire logic CLK, SYS_RST, PSEL, PENABLE, PREADY, STATIC_DONE, SDRAM_DONE,
  input wire logic SYS_REQ_STATIC, IMG_REQ_STATIC, SYS_GNT_STATIC, IMG_GNT_STATIC,
  input wire logic SYS_GNT_SDRAM, IMG_GNT_SDRAM);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // Short names for the grants
  wire logic s = SYS_GNT_STATIC, i = IMG_GNT_STATIC, d = SYS_GNT_SDRAM | IMG_GNT_SDRAM;
  one_static_a: assert property (!(s && i)) else $error("two grants");
  one_sdram_a: assert property (!(SYS_GNT_SDRAM && IMG_GNT_SDRAM)) else $error("two grants");
  apb_wait_a: assert property (PSEL && !PENABLE |=> !PREADY ##1 PREADY) else $error("ready");
  img_cause_a: assert property ($rose(i) |-> $past(IMG_REQ_STATIC)) else $error("no request");
  sys_hold_a: assert property (s && !STATIC_DONE |=> s) else $error("grant lost");
  img_drop_a: assert property (i && STATIC_DONE |=> !i) else $error("grant kept");
  sdram_drop_a: assert property (d && SDRAM_DONE |=> !d) else $error("grant kept");
  idle_grant_a:
    assert property (!(s || i) && (SYS_REQ_STATIC || IMG_REQ_STATIC) |=> s || i) else $error("idle");
  cover property (s && SYS_GNT_SDRAM);
  cover property (i && IMG_GNT_SDRAM);
  cover property ($rose(i));
endmodule // bmx_chk
bind bmx_arbitration_core bmx_chk u_chk(.*);
`default_nettype wire

//--- tb/bmx_mem.sv
`timescale 1ns/1ps
`default_nettype none
// Memory side: ends a granted transfer with a one-cycle done pulse D+1 cycles after the grant
module bmx_mem(input wire logic CLK, G, input wire logic [3:0] D, output var logic DN = 0);
  int n = 0;
  always @(posedge CLK)
  begin
    DN <= G && !DN && n >= D;
    n <= (G && !DN && n < D) ? n + 1 : 0;
  end
endmodule // bmx_mem
`default_nettype wire

//--- tb/bmx_arbitration_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module bmx_arbitration_core_bench;
  logic CLK = 0, SYS_RST = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, PREADY, PSLVERR, w, last = 0;
  logic gs, gi, gd, ge, ds, dd;
  logic [31:0] PADDR = 0, PWDATA = 0, PRDATA, v, q[$], qd[$];
  logic [1:0] pd = 0;
  logic [3:0] rq = 0, dl = 1;
  logic [1:0] pg = 0, md[4] = '{1, 0, 2, 3};
  int err_count = 0, tests_run = 0, j;
  always #20 CLK = ~CLK;
  bmx_arbitration_core dut(.CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA, .PRDATA, .PREADY,
    .PSLVERR, .SYS_REQ_STATIC(rq[0]), .IMG_REQ_STATIC(rq[1]), .SYS_REQ_SDRAM(rq[2]),
    .IMG_REQ_SDRAM(rq[3]), .STATIC_DONE(ds), .SDRAM_DONE(dd), .SYS_GNT_STATIC(gs),
    .IMG_GNT_STATIC(gi), .SYS_GNT_SDRAM(gd), .IMG_GNT_SDRAM(ge));
  bmx_mem m0(.CLK, .G(gs | gi), .D(dl), .DN(ds));
  bmx_mem m1(.CLK, .G(gd | ge), .D(dl), .DN(dd));
  task tally_and_finish(input int t);
    err_count += t;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, g);
    tests_run++;
    if (e !== g)
    begin
      err_count++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask
  // Held until PREADY; a read notes d as expected
  task apb(input logic wr, input logic [31:0] a, d);
    int k;
    if (!wr) q.push_back(d);
    PSEL <= 1; PWRITE <= wr; PADDR <= a; PWDATA <= d;
    @(posedge CLK) PENABLE <= 1;
    for (k = 0; k < 20 && !(PREADY && PENABLE); k++) @(posedge CLK);
    if (k == 20) tally_and_finish(1);
    PSEL <= 0; PENABLE <= 0;
    @(posedge CLK);
  endtask
  // Reads and fresh grants of each port meet the oldest note of their queue
  always @(posedge CLK)
  begin
    pg <= {gi, gs};
    pd <= {ge, gd};
    if (PSEL && PENABLE && PREADY) chk("error", PADDR != 32'h40ce0000 && PADDR != 32'h40ce0004, PSLVERR);
    if (PSEL && PENABLE && PREADY && !PWRITE) chk("read", q.size() ? q.pop_front() : 'x, PRDATA);
    if (pg == 0 && {gi, gs} != 0) chk("grant", q.size() ? q.pop_front() : 'x, {30'h0, gi, gs});
    if (pd == 0 && {ge, gd} != 0) chk("sdram grant", qd.size() ? qd.pop_front() : 'x, {30'h0, ge, gd});
  end
  initial
  begin
    v = $urandom(57);
    repeat (16) @(posedge CLK);
    SYS_RST <= 0;
    @(posedge CLK);
    apb(0, 32'h40ce0000, 0);
    apb(0, 32'h40ce0004, 0);
    apb(0, 32'h40ce0008, 0);
    v = $urandom;
    apb(1, 32'h40ce0000, v);
    apb(1, 32'h40ce0004, v >> 2);
    apb(0, 32'h40ce0000, v & 3);
    apb(0, 32'h40ce0004, (v >> 2) & 3);
    $display("test registers done");
    foreach (md[k])
    begin
      apb(1, 32'h40ce0000, md[k]);
      apb(1, 32'h40ce0004, md[k]);
      for (j = 0; j < 3; j++)
      begin
        w = md[k][0] ? !last : md[k][1];
        last = w;
        q.push_back(w ? 2 : 1);
        qd.push_back(w ? 2 : 1);
      end
      dl <= 1 + $urandom % 4;
      rq <= 4'hf;
      for (j = 0; j < 300 && (q.size() || qd.size()); j++) @(negedge CLK);
      if (q.size() || qd.size()) tally_and_finish(1);
      @(posedge CLK);
      rq <= 0;
      $display("test mode %0d done", md[k]);
    end
    tally_and_finish(0);
  end
endmodule // bmx_arbitration_core_bench
`default_nettype wire
